// *** src/ordf_top.sv ***
// Receive demultiplexer with A1/A2 framing, alarms and byte clock divider.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module ordf_top
   import ordf_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Receive serial stream and framing control pins
   input  wire logic              rx_serial_data,
   input  wire logic              framing_hunt_enable,
   input  wire logic              lost_alignment_input,
   // Analog monitor flags and clock inputs
   input  wire logic              cdr_clock_lost,
   input  wire logic              laser_power_low,
   input  wire logic              wavelength_deviated,
   input  wire logic              tx_pll_locked,
   input  wire logic              tx_input_word_clock,
   // Receive parallel side
   output logic      [WORD_W-1:0] rx_parallel_word,
   output logic                   rx_word_clock,
   output logic                   frame_pulse_out,
   output logic                   frame_hunt_active,
   // Alarms
   output logic                   signal_lost_n,
   output logic                   laser_degrade_alarm_n,
   output logic                   wavelength_drift_alarm,
   output logic                   synth_lock_n,
   // Transmit timing
   output logic                   tx_byte_clock,
   output logic                   phase_violation_pulse
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [7:0] pins_s;
   logic       sd_s;
   logic       en_s;
   logic       oof_s;
   logic       los_s;
   logic       pwr_s;
   logic       wdev_s;
   logic       lock_s;
   logic       tx_input_word_clock_s;

   ordf_sync #(.W(8)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({rx_serial_data, framing_hunt_enable,
                  lost_alignment_input, cdr_clock_lost, laser_power_low,
                  wavelength_deviated, tx_pll_locked,
                  tx_input_word_clock}),
      .sync_out (pins_s)
   );

   assign {sd_s, en_s, oof_s, los_s, pwr_s, wdev_s, lock_s, tx_input_word_clock_s} =
      pins_s;

   // ------------------------------------------------------------------
   // Register interface
   // ------------------------------------------------------------------
   logic             rx_enable;
   logic             hunt_request;
   logic [CNT_W-1:0] frame_count_reg;
   logic [CNT_W-1:0] frame_count_next;
   ordf_status_t     status;
   logic [3:0]       align_reg;
   logic [3:0]       align_next;

   assign status = '{align_phase:      align_reg,
                     synth_lock_n:     synth_lock_n,
                     wavelength_drift: wavelength_drift_alarm,
                     laser_degrade_n:  laser_degrade_alarm_n,
                     signal_lost_n:    signal_lost_n,
                     hunt_active:      frame_hunt_active};

   ordf_apb u_apb (
      .pclk         (pclk),
      .presetn      (presetn),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .status       (status),
      .frame_count  (frame_count_reg),
      .rx_enable    (rx_enable),
      .hunt_request (hunt_request)
   );

   // ------------------------------------------------------------------
   // Clock divider
   // ------------------------------------------------------------------
   // One bit per pclk cycle; both byte-rate clocks come from one counter,
   // so they stop together under reset.
   logic [3:0] div_reg;
   logic [3:0] div_next;
   logic       wclk_next;
   logic       wfall;

   always_comb
   begin
      div_next  = div_reg + 4'h1;
      wclk_next = ~div_next[3];
      wfall     = (div_reg == DIV_FALL);
   end

   // ------------------------------------------------------------------
   // Serial path and framing
   // ------------------------------------------------------------------
   logic [PAT_W-1:0]  shift_reg;
   logic [PAT_W-1:0]  shift_next;
   logic [WORD_W-1:0] hold_reg;
   logic [WORD_W-1:0] hold_next;
   logic [WORD_W-1:0] word_next;
   logic              hit;
   logic              realign;
   logic              fp_pend_reg;
   logic              fp_pend_next;
   logic              fp_next;
   ordf_hunt_t        state_reg;
   ordf_hunt_t        state_next;
   logic [4:0]        tail_reg;
   logic [4:0]        tail_next;
   logic              oof_prev_reg;
   logic              start;

   always_comb
   begin
      shift_next = shift_reg;
      if (rx_enable)
      begin
         shift_next = {shift_reg[PAT_W-2:0], sd_s};
      end
      hit = rx_enable && (shift_next == FRAME_PATTERN);
      start = en_s && ((oof_s && !oof_prev_reg) || hunt_request);
      realign = (state_reg == ORDF_HUNT) && en_s && hit;

      // Holding register loads on the located boundary only.
      hold_next  = hold_reg;
      align_next = align_reg;
      if (rx_enable)
      begin
         align_next = realign ? 4'h0 : align_reg + 4'h1;
         if (realign || align_reg == ALIGN_LAST)
         begin
            hold_next = shift_next[WORD_W-1:0];
         end
      end

      state_next = state_reg;
      tail_next  = tail_reg;
      case (state_reg)
         ORDF_IDLE:
         begin
            if (start)
            begin
               state_next = ORDF_HUNT;
            end
         end
         ORDF_HUNT:
         begin
            if (!en_s)
            begin
               state_next = ORDF_IDLE;
            end
            else if (hit)
            begin
               state_next = ORDF_TAIL;
               tail_next  = 5'h0;
            end
         end
         ORDF_TAIL:
         begin
            tail_next = tail_reg + 5'h1;
            if (start)
            begin
               state_next = ORDF_HUNT;
            end
            else if (tail_reg == TAIL_LAST)
            begin
               state_next = ORDF_IDLE;
            end
         end
         default:
         begin
            state_next = ORDF_IDLE;
         end
      endcase

      // A pattern seen in the update cycle itself is kept, not dropped.
      fp_pend_next = (fp_pend_reg && !wfall) || (hit && en_s);
      fp_next      = frame_pulse_out;
      word_next    = rx_parallel_word;
      frame_count_next = frame_count_reg;
      if (wfall)
      begin
         fp_next   = fp_pend_reg;
         word_next = hold_reg;
         if (fp_pend_reg)
         begin
            frame_count_next = frame_count_reg + 16'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Alarms and transmit phase check
   // ------------------------------------------------------------------
   logic wdev_prev_reg;
   logic tx_input_word_clock_prev_reg;
   logic viol_pend_reg;
   logic viol_pend_next;
   logic viol_next;
   logic wdrift_next;
   logic byte_fall;

   always_comb
   begin
      wdrift_next = wavelength_drift_alarm;
      if (wdev_s && !wdev_prev_reg)
      begin
         wdrift_next = ~wavelength_drift_alarm;
      end
      // The input word clock is only seen after the synchroniser, so
      // the window is widened by one cycle either side of the load point.
      byte_fall = (div_reg == DIV_FALL);
      viol_pend_next = (viol_pend_reg && !byte_fall) ||
                       (tx_input_word_clock_s && !tx_input_word_clock_prev_reg &&
                        (div_reg >= PHASE_WIN_HI ||
                         div_reg <= PHASE_WIN_LO));
      viol_next = byte_fall ? viol_pend_reg : phase_violation_pulse;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg                <= DIV_LAST;
         rx_word_clock          <= 1'b0;
         tx_byte_clock          <= 1'b0;
         shift_reg              <= '0;
         hold_reg               <= '0;
         align_reg              <= 4'h0;
         rx_parallel_word       <= '0;
         frame_pulse_out        <= 1'b0;
         fp_pend_reg            <= 1'b0;
         frame_count_reg        <= '0;
         state_reg              <= ORDF_IDLE;
         tail_reg               <= 5'h0;
         frame_hunt_active      <= 1'b0;
         oof_prev_reg           <= 1'b0;
         signal_lost_n          <= 1'b0;
         laser_degrade_alarm_n  <= 1'b0;
         wavelength_drift_alarm <= 1'b0;
         synth_lock_n           <= 1'b0;
         wdev_prev_reg          <= 1'b0;
         tx_input_word_clock_prev_reg         <= 1'b0;
         viol_pend_reg          <= 1'b0;
         phase_violation_pulse  <= 1'b0;
      end
      else
      begin
         div_reg                <= div_next;
         rx_word_clock          <= wclk_next;
         tx_byte_clock          <= wclk_next;
         shift_reg              <= shift_next;
         hold_reg               <= hold_next;
         align_reg              <= align_next;
         rx_parallel_word       <= word_next;
         frame_pulse_out        <= fp_next;
         fp_pend_reg            <= fp_pend_next;
         frame_count_reg        <= frame_count_next;
         state_reg              <= state_next;
         tail_reg               <= tail_next;
         frame_hunt_active      <= (state_next != ORDF_IDLE);
         oof_prev_reg           <= oof_s;
         signal_lost_n          <= ~los_s;
         laser_degrade_alarm_n  <= ~pwr_s;
         wavelength_drift_alarm <= wdrift_next;
         synth_lock_n           <= ~lock_s;
         wdev_prev_reg          <= wdev_s;
         tx_input_word_clock_prev_reg         <= tx_input_word_clock_s;
         viol_pend_reg          <= viol_pend_next;
         phase_violation_pulse  <= viol_next;
      end
   end

endmodule : ordf_top

// *** src/ordf_pkg.sv ***
// Constants, types and register map of the receive demultiplexer block.
// Notes on behaviour
// - Output word bit 15 is earliest bit.
// - Word clock out; word, pulse change on fall.
// - Pattern match gives one-word-clock frame pulse.
// - Hunt output high during whole search.
// - Hunt output stays one word period past match; the code holds it 17 cycles past the match cycle (TAIL_LAST is 16).
// - Signal-lost output low on lost recovered clock.
// - Laser alarm low when power drops 2 dB.
// - Transmit byte clock is bit clock over 16.
// - Phase violation pulse per byte-clock cycle, falling.
// - Wavelength alarm toggles on each drift excursion.
// - Synth lock output low once PLL locked.
// - Serial data feeds converter and frame detector.
// - Serial bits enter 32-bit shift register.
// - Holding register loads only on word boundaries.
// - Output register loads holding word each fall.
// - Pattern is three A1 then one A2.
// - Lost-alignment rise starts search; match ends it.
// - Enable low freezes last found word boundary.
// - Reset clears state, stops both clocks.
package ordf_pkg;

   // ------------------------------------------------------------------
   // Framing
   // ------------------------------------------------------------------
   localparam int          WORD_W        = 16;
   localparam int          PAT_W         = 32;
   localparam logic [7:0]  A1_BYTE       = 8'hf6;
   localparam logic [7:0]  A2_BYTE       = 8'h28;
   localparam logic [31:0] FRAME_PATTERN =
      {A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE};

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int         CLK_HZ       = 20_000_000;
   localparam int         BIT_DIV      = 16;
   localparam logic [3:0] DIV_LAST     = 4'hf;
   localparam logic [3:0] DIV_FALL     = 4'h7;
   localparam logic [3:0] ALIGN_LAST   = 4'hf;
   localparam logic [4:0] TAIL_LAST    = 5'h10;
   localparam logic [3:0] PHASE_WIN_LO = 4'h1;
   localparam logic [3:0] PHASE_WIN_HI = 4'hf;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  CTRL_OFF     = 8'h00;
   localparam logic [7:0]  STAT_OFF     = 8'h04;
   localparam logic [7:0]  FRAMES_OFF   = 8'h08;
   localparam int          CTRL_RX_EN   = 0;
   localparam int          CTRL_HUNT    = 1;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
   localparam int          CNT_W        = 16;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ORDF_IDLE = 2'b00,
      ORDF_HUNT = 2'b01,
      ORDF_TAIL = 2'b10
   } ordf_hunt_t;

   typedef struct packed {
      logic [3:0] align_phase;
      logic       synth_lock_n;
      logic       wavelength_drift;
      logic       laser_degrade_n;
      logic       signal_lost_n;
      logic       hunt_active;
   } ordf_status_t;

endpackage : ordf_pkg

// *** src/ordf_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module ordf_sync
   import ordf_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Pins and synchronised copies
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : ordf_sync

// *** src/ordf_apb.sv ***
// APB slave holding the control, status and frame count registers.
`timescale 1ns/1ps
module ordf_apb
   import ordf_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Block side
   input  wire ordf_status_t      status,
   input  wire logic [CNT_W-1:0]  frame_count,
   output logic                   rx_enable,
   output logic                   hunt_request
);

   logic [31:0] prdata_next;
   logic        pready_next;
   logic        pslverr_next;
   logic        rx_enable_next;
   logic        hunt_request_next;
   logic        setup;
   logic        wr;
   logic        mapped;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Read data is latched in the setup cycle so that the access phase
   // completes with no wait state.
   always_comb
   begin
      setup             = psel && !penable;
      wr                = psel && penable && pready && pwrite;
      mapped            = (paddr == CTRL_OFF) || (paddr == STAT_OFF) ||
                          (paddr == FRAMES_OFF);
      prdata_next       = prdata;
      pready_next       = setup;
      pslverr_next      = setup && !mapped;
      rx_enable_next    = rx_enable;
      hunt_request_next = 1'b0;
      if (setup && !pwrite)
      begin
         case (paddr)
            CTRL_OFF:   prdata_next = {31'h0, rx_enable};
            STAT_OFF:   prdata_next = {23'h0, status};
            FRAMES_OFF: prdata_next = {16'h0, frame_count};
            default:    prdata_next = 32'h0;
         endcase
      end
      if (wr && paddr == CTRL_OFF)
      begin
         rx_enable_next    = pwdata[CTRL_RX_EN];
         hunt_request_next = pwdata[CTRL_HUNT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata       <= 32'h0;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         rx_enable    <= CTRL_RESET[CTRL_RX_EN];
         hunt_request <= 1'b0;
      end
      else
      begin
         prdata       <= prdata_next;
         pready       <= pready_next;
         pslverr      <= pslverr_next;
         rx_enable    <= rx_enable_next;
         hunt_request <= hunt_request_next;
      end
   end

endmodule : ordf_apb

// *** sim/ordf_top_asserts.sv ***
// Concurrent checks on the ports of the receive demultiplexer.
`timescale 1ns/1ps
module ordf_top_asserts
   import ordf_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // Bus answer
   input wire logic              pready,
   input wire logic              pslverr,
   // Monitor inputs
   input wire logic              cdr_clock_lost,
   input wire logic              laser_power_low,
   input wire logic              wavelength_deviated,
   input wire logic              tx_pll_locked,
   // Receive and alarm outputs
   input wire logic [WORD_W-1:0] rx_parallel_word,
   input wire logic              rx_word_clock,
   input wire logic              frame_pulse_out,
   input wire logic              frame_hunt_active,
   input wire logic              signal_lost_n,
   input wire logic              laser_degrade_alarm_n,
   input wire logic              wavelength_drift_alarm,
   input wire logic              synth_lock_n,
   input wire logic              tx_byte_clock,
   input wire logic              phase_violation_pulse
);
   // ------------------------------------------------------------------
   // Frame pulse length
   // ------------------------------------------------------------------
   logic [4:0] fp_len_reg;
   logic [4:0] fp_len_next;

   always_comb
   begin
      fp_len_next = frame_pulse_out ? fp_len_reg + 5'h01 : 5'h00;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fp_len_reg <= 5'h00;
      else
         fp_len_reg <= fp_len_next;
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_word_on_fall: assert property (
      $changed(rx_parallel_word) |-> !rx_word_clock)
      else $error("word moved while clock high");
   chk_pulse_width: assert property (
      $fell(frame_pulse_out) |-> fp_len_reg == 5'h10)
      else $error("frame pulse width wrong");
   chk_clock_high: assert property (
      $rose(rx_word_clock) |-> rx_word_clock[*8] ##1 !rx_word_clock)
      else $error("word clock high phase wrong");
   chk_clock_low: assert property (
      $fell(rx_word_clock) |-> (!rx_word_clock)[*8] ##1 rx_word_clock)
      else $error("word clock low phase wrong");
   chk_byte_clock: assert property (
      tx_byte_clock == rx_word_clock)
      else $error("byte clock off word clock");
   chk_phase_fall: assert property (
      $changed(phase_violation_pulse) |-> !tx_byte_clock)
      else $error("phase pulse moved off fall");
   chk_hunt_tail: assert property (
      $rose(frame_pulse_out) && frame_hunt_active
      |-> ##[1:16] !frame_hunt_active)
      else $error("hunt did not end");
   chk_los_low: assert property (
      cdr_clock_lost[*4] |-> !signal_lost_n)
      else $error("signal lost not low");
   chk_laser_low: assert property (
      laser_power_low[*4] |-> !laser_degrade_alarm_n)
      else $error("laser alarm not low");
   chk_lock_low: assert property (
      tx_pll_locked[*4] |-> !synth_lock_n)
      else $error("lock output not low");
   chk_drift_toggle: assert property (
      $changed(wavelength_drift_alarm)
      |-> $past(wavelength_deviated, 3) && !$past(wavelength_deviated, 4))
      else $error("drift toggle without edge");

   cov_frame: cover property ($rose(frame_pulse_out));
   cov_hunt_end: cover property ($fell(frame_hunt_active));
   cov_phase: cover property ($rose(phase_violation_pulse));
   cov_refused: cover property (pready && pslverr);
endmodule : ordf_top_asserts

bind ordf_top ordf_top_asserts u_chk (
   .pclk, .presetn, .pready, .pslverr, .cdr_clock_lost, .laser_power_low,
   .wavelength_deviated, .tx_pll_locked, .rx_parallel_word, .rx_word_clock,
   .frame_pulse_out, .frame_hunt_active, .signal_lost_n,
   .laser_degrade_alarm_n, .wavelength_drift_alarm, .synth_lock_n,
   .tx_byte_clock, .phase_violation_pulse
);

// *** sim/ordf_sink.sv ***
// Downstream overhead logic: asks for a hunt and takes framed words.
`timescale 1ns/1ps
module ordf_sink
   import ordf_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Demultiplexer outputs
   input  wire logic [WORD_W-1:0] rx_parallel_word,
   input  wire logic              frame_pulse_out,
   // Hunt request from the bench and alignment pin
   input  wire logic              start_hunt,
   output logic                   lost_alignment_input,
   // First two words of each frame
   output logic                   word_valid,
   output logic      [WORD_W-1:0] word_seen
);
   logic       fp_prev;
   logic       fp_rise;
   logic [4:0] gap;
   logic [2:0] oof_cnt;

   assign fp_rise = frame_pulse_out && !fp_prev;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {fp_prev, gap, oof_cnt, word_valid, word_seen} <= '0;
         lost_alignment_input <= 1'b0;
      end
      else
      begin
         fp_prev <= frame_pulse_out;
         // The pin rise is held long enough to pass the synchroniser.
         oof_cnt <= start_hunt ? 3'h4 : oof_cnt - 3'(oof_cnt != 3'h0);
         lost_alignment_input <= (oof_cnt != 3'h0);
         word_valid <= fp_rise || gap == 5'h01;
         word_seen <= rx_parallel_word;
         gap <= fp_rise ? 5'h10 : gap - 5'(gap != 5'h00);
      end
   end
endmodule : ordf_sink

// *** sim/tb_oc48_rx_demux_framing.sv ***
// Self-checking testbench of the receive demultiplexer.
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tb_oc48_rx_demux_framing
   import ordf_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd, r;
   logic              err, rx_serial_data, framing_hunt_enable, lost_align;
   logic              cdr, laser, wave, pll, tx_in_clk, start_hunt;
   logic [15:0]       rx_word, word_seen, exp_w;
   logic              word_clk, fp, hunt, los_n, laser_n, drift, lock_n;
   logic              byte_clk, phase, word_valid, drift_exp;
   logic [15:0]       exp_q[$];
   int                n_errors, tests_run;

   ordf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_serial_data,
      .framing_hunt_enable,
      .lost_alignment_input(lost_align), .cdr_clock_lost(cdr),
      .laser_power_low(laser), .wavelength_deviated(wave),
      .tx_pll_locked(pll), .tx_input_word_clock(tx_in_clk),
      .rx_parallel_word(rx_word), .rx_word_clock(word_clk),
      .frame_pulse_out(fp), .frame_hunt_active(hunt),
      .signal_lost_n(los_n), .laser_degrade_alarm_n(laser_n),
      .wavelength_drift_alarm(drift), .synth_lock_n(lock_n),
      .tx_byte_clock(byte_clk), .phase_violation_pulse(phase));

   ordf_sink u_sink (.pclk, .presetn, .rx_parallel_word(rx_word),
      .frame_pulse_out(fp), .start_hunt, .word_valid, .word_seen,
      .lost_alignment_input(lost_align));

   // ------------------------------------------------------------------
   // Clocks and tasks
   // ------------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Period of ten cycles drifts through every second byte clock phase, eight of the sixteen.
   initial
   begin
      tx_in_clk = 1'b0;
      forever
      begin
         repeat (5) @(posedge pclk);
         tx_in_clk <= ~tx_in_clk;
      end
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic wait_hunt(input logic lvl);
      int n;
      n = 0;
      while (hunt !== lvl && n < 80)
      begin
         @(posedge pclk);
         n++;
      end
      if (hunt !== lvl)
      begin
         n_errors++;
         stop_test();
      end
   endtask : wait_hunt

   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge pclk);
         rx_serial_data <= v[i];
      end
   endtask : send

   task automatic frame_seq(input logic expect_frame);
      logic [15:0] w;
      w = 16'($urandom);
      if (expect_frame)
      begin
         exp_q.push_back({A1_BYTE, A2_BYTE});
         exp_q.push_back(w);
      end
      send(FRAME_PATTERN, 32);
      send({16'h0000, w}, 16);
      send($urandom, 32);
      send($urandom, 32);
   endtask : frame_seq

   // ------------------------------------------------------------------
   // Word monitor
   // ------------------------------------------------------------------
   always @(posedge pclk)
   begin
      if (word_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            `CHECK(word_valid, 1'b0)
         else
         begin
            exp_w = exp_q.pop_front();
            `CHECK(word_seen, exp_w)
         end
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {rx_serial_data, cdr, laser, wave, pll, start_hunt} = '0;
      {n_errors, tests_run, drift_exp} = '0;
      framing_hunt_enable = 1'b1;
      presetn = 1'b0;
      void'($urandom(89251));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFF, 32'h0);
      `CHECK(rd, CTRL_RESET)
      send($urandom, 32);
      start_hunt <= 1'b1;
      @(posedge pclk);
      start_hunt <= 1'b0;
      wait_hunt(1'b1);
      `CHECK(hunt, 1'b1)
      frame_seq(1'b1);
      wait_hunt(1'b0);
      `CHECK(exp_q.size(), 0)
      framing_hunt_enable <= 1'b0;
      repeat (4) @(posedge pclk);
      frame_seq(1'b0);
      framing_hunt_enable <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b1, CTRL_OFF, 32'h3);
      wait_hunt(1'b1);
      frame_seq(1'b1);
      wait_hunt(1'b0);
      apb(1'b0, FRAMES_OFF, 32'h0);
      `CHECK(rd, 32'h2)
      for (int i = 0; i < 6; i++)
      begin
         r = $urandom;
         cdr <= r[0];
         laser <= r[1];
         pll <= r[3];
         wave <= i[0];
         drift_exp = drift_exp ^ i[0];
         repeat (6) @(posedge pclk);
         `CHECK(los_n, !r[0])
         `CHECK(laser_n, !r[1])
         `CHECK(lock_n, !r[3])
         `CHECK(drift, drift_exp)
      end
      apb(1'b0, STAT_OFF, 32'h0);
      `CHECK(rd[4:0], {!r[3], drift_exp, !r[1], !r[0], 1'b0})
      apb(1'b0, 8'h0c, 32'h0);
      `CHECK(err, 1'b1)
      `CHECK(rd, 32'h0)
      stop_test();
   end
endmodule : tb_oc48_rx_demux_framing
